// ---- rtl/pmsm_cfg.svh ----
/*
 * Constants of the power state controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz mclk and word-aligned Avalon-MM byte addresses.
 */
// Behaviour
// [RULE1] Standby to run when pin differs polarity; the code returns to run when the pin matches it
// [RULE2] Run to standby when pin matches polarity; the code enters standby when the pin differs from it
// [RULE3] Hard watchdog event sends system-on to reset
// [RULE4] After 30 us, below limit, back on
// [RULE5] Tally at limit leads to fault power-down
// [RULE6] Safety part: deep off to self-test
// [RULE7] Level mode power-up event conditions
// [RULE8] Edge mode: falling power-on pin triggers
// [RULE9] Bring-up pin high passes to quick-start off
// [RULE10] Self-test pass or bring-up: quick-start off
// [RULE11] Basic part skips self-test entirely
// [RULE12] System drives power-on pin to request start
// [RULE13] Tally counts entries, compared with limit
`ifndef PMSM_CFG_SVH
`define PMSM_CFG_SVH

// ==========================================================
// Timing
`define PMSM_CLK_NS       20
`define PMSM_WD_WAIT_NS   30000
`define PMSM_WD_WAIT_CYC  ((`PMSM_WD_WAIT_NS + `PMSM_CLK_NS - 1) / `PMSM_CLK_NS)

// ==========================================================
// Register offsets
`define PMSM_ADDR_CTRL    5'h00
`define PMSM_ADDR_WDOG    5'h04
`define PMSM_ADDR_STATE   5'h08
`define PMSM_ADDR_IRQ_ST  5'h0c
`define PMSM_ADDR_IRQ_MSK 5'h10

// ==========================================================
// Fields and reset values
`define PMSM_WDOG_CLR     7
`define PMSM_IRQ_RUN      0
`define PMSM_IRQ_STBY     1
`define PMSM_IRQ_WD       2
`define PMSM_IRQ_FAULT    3
`define PMSM_IRQ_QSO      4
`define PMSM_IRQ_W        5
`define PMSM_CTRL_RST     4'h8
`define PMSM_LIMIT_RST    4'h3
`define PMSM_MASK_RST     5'h00

`endif

// ---- rtl/pmsm_pkg.sv ----
/*
 * Types of the power state controller.
 * Assumes pmsm_cfg.svh for all numeric constants.
 */
package pmsm_pkg;

	// ======================================================
	// Power states, read back in this order as codes 0..6
	typedef enum logic [2:0] {
		st_deep_off,
		st_self_test,
		st_quick_start_off,
		st_run,
		st_standby,
		st_wdog_reset,
		st_fault_pd
	} pmsm_state_t;

	// ======================================================
	// Internal monitor flags
	typedef struct packed {
		logic vin_above_uv;
		logic vin_above_ov;
		logic tj_above_tsd;
		logic trim_load_error;
		logic fuse_load_error;
	} pmsm_mon_t;

	// Control register layout, bit 3 down to bit 0
	typedef struct packed {
		logic ovlo_en;
		logic power_on_edge_select;
		logic low_power_off_select;
		logic sleep_pin_polarity;
	} pmsm_ctrl_t;

endpackage : pmsm_pkg

// ---- rtl/pmsm_delay_timer.sv ----
/*
 * One-shot delay timer: done is high in the last cycle of the wait.
 * Assumes start is a one-cycle pulse; a new start restarts the wait.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pmsm_cfg.svh"

module pmsm_delay_timer #(
	parameter int CYCLES = `PMSM_WD_WAIT_CYC,
	localparam int W     = $clog2(CYCLES + 1)
) (
	input  wire logic mclk,  // Clock
	input  wire logic reset, // Sync reset
	input  wire logic start, // Begin wait
	output logic      done   // Wait over
);
	logic [W-1:0] cnt;
	logic         running;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt     <= '0;
			running <= 1'b0;
		end else if (start) begin
			cnt     <= W'(CYCLES - 1);
			running <= 1'b1;
		end else if (running) begin
			if (cnt == '0)
				running <= 1'b0;
			else
				cnt <= cnt - 1'b1;
		end
	end

	assign done = running && (cnt == '0);

endmodule : pmsm_delay_timer
`default_nettype wire

// ---- rtl/pmsm_fall_det.sv ----
/*
 * High-to-low edge detector for a synchronous pin.
 * Assumes the pin is already synchronous to mclk.
 */
`timescale 1ns/1ns
`default_nettype none

module pmsm_fall_det (
	input  wire logic mclk,  // Clock
	input  wire logic reset, // Sync reset
	input  wire logic level, // Pin level
	output logic      fall   // One-cycle fall
);
	logic prev;

	// Reset low so a pin held low at release is no edge
	always_ff @(posedge mclk) begin
		if (reset)
			prev <= 1'b0;
		else
			prev <= level;
	end

	assign fall = prev & ~level;

endmodule : pmsm_fall_det
`default_nettype wire

// ---- rtl/pmsm_main.sv ----
/*
 * Power state controller: deep off, self-test, quick-start off,
 * run/standby and watchdog reset handling, with Avalon-MM registers
 * and a maskable interrupt.
 * Assumes all pins and monitor flags are synchronous to mclk, and that
 * reset is raised on supply loss.
 */
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pmsm_cfg.svh"

module pmsm_main #(
	parameter bit SAFETY_VARIANT = 1'b1,
	parameter int WD_WAIT_CYC    = `PMSM_WD_WAIT_CYC
) (
	input  wire logic              mclk,             // 50 MHz clock
	input  wire logic              reset,            // Sync reset
	input  wire logic              standby_pin,      // Standby request
	input  wire logic              power_on_pin,     // Power-on request
	input  wire logic              test_bringup_pin, // Bring-up mode
	input  wire logic              hard_wdog_event,  // Hard wd reset
	input  wire logic              selftest_pass,    // Self-tests ok
	input  wire logic              seq_done,         // Power-up done
	input  wire pmsm_pkg::pmsm_mon_t monitors,       // Monitor flags
	input  wire logic [4:0]        avs_address,      // Byte address
	input  wire logic              avs_read,         // Read strobe
	input  wire logic              avs_write,        // Write strobe
	input  wire logic [31:0]       avs_writedata,    // Write data
	input  wire logic [3:0]        avs_byteenable,   // Byte lanes
	output logic [31:0]            avs_readdata,     // Read data
	output logic                   avs_waitrequest,  // Stall
	output logic                   irq,              // Interrupt
	output logic                   sys_on,           // Run or standby
	output logic                   fault_pd,         // Fault power-down
	output logic [2:0]             state_code        // Current state
);
	import pmsm_pkg::*;

	pmsm_state_t             st;
	pmsm_state_t             next_st;
	pmsm_ctrl_t              ctrl;
	logic [3:0]              wdog_reset_limit;
	logic [3:0]              wdog_reset_tally;
	logic [`PMSM_IRQ_W-1:0]  irq_status;
	logic [`PMSM_IRQ_W-1:0]  irq_mask;
	logic [`PMSM_IRQ_W-1:0]  irq_event;
	logic [`PMSM_IRQ_W-1:0]  irq_clr;
	logic                    ack;
	logic                    rd_en;
	logic                    wr_en;
	logic                    tally_clr;
	logic                    pon_fall;
	logic                    wd_done;
	logic                    wd_start;
	logic                    mon_ok;
	logic                    trig;
	logic                    pwr_event;
	logic                    go_up;
	logic                    standby_asserted;

	// ======================================================
	// Avalon-MM slave, one wait cycle per access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign rd_en           = avs_read & ~ack;
	assign wr_en           = avs_write & ack & avs_byteenable[0];

	always_ff @(posedge mclk) begin
		if (reset)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			avs_readdata <= '0;
		end else if (rd_en) begin
			case (avs_address)
			`PMSM_ADDR_CTRL:    avs_readdata <= {28'h0, ctrl};
			`PMSM_ADDR_WDOG:    avs_readdata <= {20'h0,
				wdog_reset_tally, 4'h0, wdog_reset_limit};
			`PMSM_ADDR_STATE:   avs_readdata <= {29'h0, st};
			`PMSM_ADDR_IRQ_ST:  avs_readdata <= {27'h0, irq_status};
			`PMSM_ADDR_IRQ_MSK: avs_readdata <= {27'h0, irq_mask};
			default:            avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl             <= `PMSM_CTRL_RST;
			wdog_reset_limit <= `PMSM_LIMIT_RST;
			irq_mask         <= `PMSM_MASK_RST;
		end else if (wr_en) begin
			if (avs_address == `PMSM_ADDR_CTRL)
				ctrl <= avs_writedata[3:0];
			if (avs_address == `PMSM_ADDR_WDOG)
				wdog_reset_limit <= avs_writedata[3:0];
			if (avs_address == `PMSM_ADDR_IRQ_MSK)
				irq_mask <= avs_writedata[`PMSM_IRQ_W-1:0];
		end
	end

	// ======================================================
	// Watchdog reset tally
	assign tally_clr = wr_en && (avs_address == `PMSM_ADDR_WDOG)
		&& avs_writedata[`PMSM_WDOG_CLR];

	// Saturates so a low limit cannot wrap back to a retry
	always_ff @(posedge mclk) begin
		if (reset)
			wdog_reset_tally <= 4'h0;
		else if (wd_start && wdog_reset_tally != 4'hf)
			wdog_reset_tally <= wdog_reset_tally + 4'h1; // RULE13
		else if (tally_clr)
			wdog_reset_tally <= 4'h0;
	end

	pmsm_delay_timer #(
		.CYCLES (WD_WAIT_CYC)
	) u_wd_timer (
		.mclk  (mclk),
		.reset (reset),
		.start (wd_start),
		.done  (wd_done)
	);

	// ======================================================
	// Start-up conditions
	pmsm_fall_det u_pon_fall (
		.mclk  (mclk),
		.reset (reset),
		.level (power_on_pin),
		.fall  (pon_fall)
	);

	assign mon_ok = monitors.vin_above_uv
		& (~monitors.vin_above_ov | ~ctrl.ovlo_en)
		& ~monitors.tj_above_tsd
		& ~monitors.trim_load_error
		& ~monitors.fuse_load_error;                   // RULE7
	assign trig = ctrl.power_on_edge_select ? pon_fall  // RULE8
		: power_on_pin;                                 // RULE7
	assign pwr_event = ~ctrl.low_power_off_select & ~test_bringup_pin
		& trig & mon_ok;
	assign go_up = test_bringup_pin                     // RULE9
		| (ctrl.low_power_off_select & ~test_bringup_pin) // RULE6
		| pwr_event;
	assign standby_asserted = standby_pin ^ ctrl.sleep_pin_polarity;
	assign wd_start = ((st == st_run) || (st == st_standby))
		&& hard_wdog_event;

	// ======================================================
	// State machine
	always_comb begin
		next_st = st;
		case (st)
		st_deep_off: begin
			if (go_up)
				next_st = SAFETY_VARIANT ? st_self_test   // RULE6
					: st_quick_start_off;                   // RULE11
		end
		st_self_test: begin
			if (selftest_pass || test_bringup_pin)
				next_st = st_quick_start_off;             // RULE10
		end
		st_quick_start_off: begin
			if (seq_done)
				next_st = st_run;
		end
		st_run: begin
			if (hard_wdog_event)
				next_st = st_wdog_reset;                  // RULE3
			else if (standby_asserted)
				next_st = st_standby;                     // RULE2
		end
		st_standby: begin
			if (hard_wdog_event)
				next_st = st_wdog_reset;                  // RULE3
			else if (!standby_asserted)
				next_st = st_run;                         // RULE1
		end
		st_wdog_reset: begin
			if (wdog_reset_tally >= wdog_reset_limit)
				next_st = st_fault_pd;                    // RULE5
			else if (wd_done)
				next_st = st_run;                         // RULE4
		end
		st_fault_pd: next_st = st_fault_pd;
		default:     next_st = st_deep_off;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset)
			st <= st_deep_off;
		else
			st <= next_st;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			sys_on     <= 1'b0;
			fault_pd   <= 1'b0;
			state_code <= 3'h0;
		end else begin
			sys_on     <= (next_st == st_run) || (next_st == st_standby);
			fault_pd   <= next_st == st_fault_pd;
			state_code <= next_st;
		end
	end

	// ======================================================
	// Interrupts
	always_comb begin
		irq_event = '0;
		if (next_st != st) begin
			irq_event[`PMSM_IRQ_RUN]   = next_st == st_run;
			irq_event[`PMSM_IRQ_STBY]  = next_st == st_standby;
			irq_event[`PMSM_IRQ_WD]    = next_st == st_wdog_reset;
			irq_event[`PMSM_IRQ_FAULT] = next_st == st_fault_pd;
			irq_event[`PMSM_IRQ_QSO]   = next_st == st_quick_start_off;
		end
	end

	assign irq_clr = (wr_en && avs_address == `PMSM_ADDR_IRQ_ST)
		? avs_writedata[`PMSM_IRQ_W-1:0] : '0;

	// New events win over a simultaneous clear
	always_ff @(posedge mclk) begin
		if (reset)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~irq_clr) | irq_event;
	end

	assign irq = |(irq_status & irq_mask);

	// ======================================================
	// Checks
	localparam int WD_LO = WD_WAIT_CYC;
	localparam int WD_HI = WD_WAIT_CYC;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_STBY_TO_RUN: assert property ( // RULE1
		st == st_standby && !hard_wdog_event && !standby_asserted
		|=> st == st_run && sys_on)
		else $error("standby did not return to run");
	AST_RUN_TO_STBY: assert property ( // RULE2
		st == st_run && !hard_wdog_event
		&& standby_pin != ctrl.sleep_pin_polarity
		|=> st == st_standby)
		else $error("run did not enter standby");
	AST_WD_ENTRY: assert property ( // RULE3
		(st == st_run || st == st_standby) && hard_wdog_event
		|=> st == st_wdog_reset && !sys_on)
		else $error("hard watchdog event not taken");
	AST_WD_RETRY: assert property ( // RULE4
		st == st_wdog_reset && wd_done
		&& wdog_reset_tally < wdog_reset_limit
		|=> st == st_run && sys_on)
		else $error("watchdog retry missing");
	AST_WD_WAIT: assert property ( // RULE4
		st == st_wdog_reset && !wd_done
		&& wdog_reset_tally < wdog_reset_limit
		|=> st == st_wdog_reset)
		else $error("watchdog wait cut short");
	AST_WD_SPAN: assert property ( // RULE4
		$rose(st == st_wdog_reset)
		&& wdog_reset_tally < wdog_reset_limit
		|-> ##[WD_LO:WD_HI] st != st_wdog_reset)
		else $error("watchdog wait too long");
	AST_WD_FAULT: assert property ( // RULE5
		st == st_wdog_reset && wdog_reset_tally == wdog_reset_limit
		|=> st == st_fault_pd ##1 fault_pd)
		else $error("tally at limit did not fault");
	AST_TALLY_COUNT: assert property ( // RULE13
		$rose(st == st_wdog_reset) && $past(wdog_reset_tally) != 4'hf
		|-> wdog_reset_tally == $past(wdog_reset_tally) + 4'h1)
		else $error("tally not counted on entry");
	AST_DEEP_EXIT: assert property ( // RULE6
		st == st_deep_off && ctrl.low_power_off_select
		|=> st == (SAFETY_VARIANT ? st_self_test : st_quick_start_off))
		else $error("transitory pass missing");
	AST_LEVEL_EVENT: assert property ( // RULE7
		st == st_deep_off && !ctrl.power_on_edge_select
		&& power_on_pin && mon_ok && !test_bringup_pin
		|=> st != st_deep_off)
		else $error("level power-up event ignored");
	AST_EDGE_EVENT: assert property ( // RULE8
		st == st_deep_off && ctrl.power_on_edge_select
		&& !ctrl.low_power_off_select && !test_bringup_pin
		&& !$fell(power_on_pin)
		|=> st == st_deep_off)
		else $error("edge mode left deep off without edge");
	// Safety part reaches quick-start off via the self-test check
	AST_BRINGUP: assert property ( // RULE9
		st == st_deep_off && test_bringup_pin
		|=> st == (SAFETY_VARIANT ? st_self_test : st_quick_start_off))
		else $error("bring-up pass missing");
	AST_SELFTEST: assert property ( // RULE10
		st == st_self_test && (selftest_pass || test_bringup_pin)
		|=> st == st_quick_start_off)
		else $error("self-test exit missing");
	AST_NO_SELFTEST: assert property ( // RULE11
		!SAFETY_VARIANT |-> st != st_self_test)
		else $error("basic part entered self-test");

	COV_START: cover property (
		st == st_deep_off ##[1:4] st == st_quick_start_off);
	COV_RETRY: cover property (
		st == st_wdog_reset ##1 st == st_run);
	COV_FAULT: cover property (st == st_fault_pd);
	COV_SLEEP: cover property (st == st_standby ##1 st == st_run);

endmodule : pmsm_main
`default_nettype wire

// ---- verif/pmsm_sys_ctrl.sv ----
/*
 * System-side model: drives the power-on and standby pins.
 * Assumes requests from the bench change just after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module pmsm_sys_ctrl (
	input  wire logic mclk,         // Clock
	input  wire logic edge_mode,    // Pulse instead of level
	input  wire logic want_on,      // Start-up request
	input  wire logic want_standby, // Standby request
	input  wire logic polarity,     // Asserting level select
	output logic      power_on_pin, // Power-on pin
	output logic      standby_pin   // Standby pin
);
	logic on_q;

	initial begin
		on_q         = 1'b0;
		power_on_pin = 1'b0;
		standby_pin  = 1'b0;
	end

	// One high cycle per new request, so the pin falls once
	always @(posedge mclk) begin
		on_q <= want_on;
		if (edge_mode)
			power_on_pin <= want_on & ~on_q;
		else
			power_on_pin <= want_on;
		standby_pin <= want_standby ^ polarity;
	end
endmodule : pmsm_sys_ctrl
`default_nettype wire

// ---- verif/pmsm_main_test.sv ----
/*
 * Self-checking bench for the power state controller, with a
 * cycle model compared at every cycle and on every register read.
 * Assumes pmsm_main with a shortened watchdog wait of 4 cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module pmsm_main_test;
	import pmsm_pkg::*;
	localparam int WD = 4;
	logic mclk, reset, pon, sbp, bup, wde, stp, sdone, want_on, want_sb;
	logic avs_read, avs_write, avs_waitrequest, irq, sys_on, fault_pd;
	logic [4:0]  avs_address, sts, msk, set, clr;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [3:0]  avs_byteenable, be, ctrl, lim, tal, t;
	logic [2:0]  state_code, m_st, ns, b_state;
	logic        mack;
	logic [7:0]  wcnt;
	logic        prev, ok, trig;
	pmsm_mon_t   mon;
	int failures, samples_checked, seed;

	pmsm_main #(.SAFETY_VARIANT(1'b1), .WD_WAIT_CYC(WD)) pmsm_main_i (
		.mclk(mclk), .reset(reset), .standby_pin(sbp),
		.power_on_pin(pon), .test_bringup_pin(bup),
		.hard_wdog_event(wde), .selftest_pass(stp), .seq_done(sdone),
		.monitors(mon), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .sys_on(sys_on),
		.fault_pd(fault_pd), .state_code(state_code));

	pmsm_sys_ctrl pmsm_sys_ctrl_i (
		.mclk(mclk), .edge_mode(ctrl[2]), .want_on(want_on),
		.want_standby(want_sb), .polarity(ctrl[0]),
		.power_on_pin(pon), .standby_pin(sbp));

	// Basic part on the same pins; only its state code is watched
	pmsm_main #(.SAFETY_VARIANT(1'b0), .WD_WAIT_CYC(WD)) pmsm_main_b_i (
		.mclk(mclk), .reset(reset), .standby_pin(sbp),
		.power_on_pin(pon), .test_bringup_pin(bup),
		.hard_wdog_event(wde), .selftest_pass(stp), .seq_done(sdone),
		.monitors(mon), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(),
		.avs_waitrequest(), .irq(), .sys_on(),
		.fault_pd(), .state_code(b_state));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ======================================================
	// Reference model
	always @(posedge mclk) begin
		if (reset) begin
			m_st <= 3'h0; ctrl <= 4'h8; lim <= 4'h3; tal <= 4'h0;
			msk <= 5'h00; sts <= 5'h00; wcnt <= 8'h00; prev <= 1'b0;
			mack <= 1'b0;
		end else begin
			ns = m_st; set = 5'h00; clr = 5'h00; t = tal;
			ok = mon.vin_above_uv & ~(mon.vin_above_ov & ctrl[3])
				& ~mon.tj_above_tsd & ~mon.trim_load_error
				& ~mon.fuse_load_error;
			trig = ctrl[2] ? (prev & ~pon) : pon;
			case (m_st)
			3'h0: if (bup | ctrl[1] | (trig & ok)) ns = 3'h1;
			3'h1: if (stp | bup) ns = 3'h2;
			3'h2: if (sdone) ns = 3'h3;
			3'h3, 3'h4: begin
				if (wde) ns = 3'h5;
				else if (m_st == 3'h3 && (sbp ^ ctrl[0])) ns = 3'h4;
				else if (m_st == 3'h4 && !(sbp ^ ctrl[0])) ns = 3'h3;
			end
			3'h5: begin
				if (tal >= lim) ns = 3'h6;
				else if (wcnt + 8'h01 == 8'(WD)) ns = 3'h3;
			end
			default: ;
			endcase
			wcnt <= (m_st == 3'h5 && ns == 3'h5) ? wcnt + 8'h01 : 8'h00;
			if (ns == 3'h5 && m_st != 3'h5 && tal != 4'hf) t = tal + 4'h1;
			if (ns != m_st && ns >= 3'h2)
				set = (ns == 3'h2) ? 5'h10 : 5'h01 << (ns - 3'h3);
			if (avs_write & mack & avs_byteenable[0]) begin
				case (avs_address)
				5'h00: ctrl <= avs_writedata[3:0];
				5'h04: begin
					lim <= avs_writedata[3:0];
					if (avs_writedata[7] && t == tal) t = 4'h0;
				end
				5'h0c: clr = avs_writedata[4:0];
				5'h10: msk <= avs_writedata[4:0];
				default: ;
				endcase
			end
			sts <= (sts & ~clr) | set;
			tal <= t;
			m_st <= ns;
			prev <= pon;
			mack <= (avs_read | avs_write) & ~mack;
		end
	end

	function automatic logic [31:0] rv(input logic [4:0] a);
		case (a)
		5'h00: rv = {28'h0, ctrl};
		5'h04: rv = {20'h0, tal, 4'h0, lim};
		5'h08: rv = {29'h0, m_st};
		5'h0c: rv = {27'h0, sts};
		5'h10: rv = {27'h0, msk};
		default: rv = 32'h0;
		endcase
	endfunction : rv

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	always @(negedge mclk) begin
		if (!reset) begin
			chk(32'(state_code), 32'(m_st));
			chk(32'(fault_pd), 32'(m_st == 3'h6));
			chk(32'(sys_on), 32'(m_st == 3'h3 || m_st == 3'h4));
			chk(32'(irq), 32'(|(sts & msk)));
			chk(32'(b_state == 3'h1), 32'h0);
		end
	end

	// ======================================================
	// Bus and stimulus
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		logic [31:0] e;
		n = 0;
		e = 32'h0;
		avs_read <= ~w; avs_write <= w; avs_address <= a;
		avs_writedata <= d; avs_byteenable <= be;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			e = rv(a);
			n++;
			@(posedge mclk);
		end
		chk(32'(n), 32'h1);
		if (!w)
			chk(avs_readdata, e);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask : step

	task automatic results;
		$display("failures %0d samples_checked %0d", failures,
			samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	initial begin
		#(20 * 40000);
		failures++;
		results();
	end

	initial begin
		seed = 32'h5c4a8a4d;
		failures = 0; samples_checked = 0; reset = 1'b1; be = 4'hf;
		bup = 0; wde = 0; stp = 0; sdone = 0; want_on = 0; want_sb = 0;
		mon = 5'b10000; avs_read = 0; avs_write = 0;
		avs_address = 5'h0; avs_writedata = 32'h0; avs_byteenable = 4'hf;
		step(10);
		reset <= 1'b0;
		step(1);
		for (int a = 0; a < 24; a += 4)
			bus(1'b0, 5'(a), 32'h0);
		bus(1'b1, 5'h10, 32'h1f);
		bus(1'b1, 5'h00, 32'h0c);
		want_on <= 1'b1; step(4);
		stp <= 1'b1; step(2);
		sdone <= 1'b1; step(2);
		bus(1'b0, 5'h0c, 32'h0);
		bus(1'b1, 5'h0c, 32'h1f);
		bus(1'b1, 5'h00, 32'h0d);
		want_sb <= 1'b1; step(3);
		want_sb <= 1'b0; step(3);
		bus(1'b1, 5'h04, 32'h82);
		repeat (3) begin
			wde <= 1'b1; step(1);
			wde <= 1'b0; step(WD + 3);
			bus(1'b0, 5'h04, 32'h0);
		end
		reset <= 1'b1; step(2);
		reset <= 1'b0; bup <= 1'b1; step(4);
		for (int i = 0; i < 3000; i++) begin
			r = $random(seed);
			mon <= {|r[1:0], &r[3:2], &r[5:4], &r[7:6], &r[9:8]};
			bup <= (r[12:10] == 3'h0); wde <= (r[16:13] == 4'h0);
			stp <= r[17]; sdone <= r[18]; want_on <= r[19];
			want_sb <= r[20]; be <= {3'h7, r[21] | r[22]};
			reset <= (i % 500 == 499);
			// No request while reset is high or on its release edge
			if (r[25:23] == 3'h0 && (i % 500) > 0
				&& (i % 500) < 499)
				bus(r[26], {r[29:27], 2'b00}, {24'h0, r[31:30], r[5:0]});
			else
				step(1);
		end
		results();
	end
endmodule : pmsm_main_test
`default_nettype wire
